// ===== hdl/emlm_pkg.sv
// shared constants and types of the isolated adc link manager
package emlm_pkg;

  // ----------------------------------------------------------------
  // clocking
  // ----------------------------------------------------------------
  localparam int unsigned    MCLK_HZ        = 10000000;
  localparam int unsigned    MCLK_PERIOD_NS = 1000000000 / MCLK_HZ;
  localparam int unsigned    FE_CLK_HZ      = 4096000;
  localparam int unsigned    STROBE_HZ      = FE_CLK_HZ / 4;
  localparam int unsigned    PHASE_W        = 24;
  localparam longint unsigned PHASE_INC_L   =
    ((longint'(1) << PHASE_W) * longint'(STROBE_HZ)) / longint'(MCLK_HZ);
  localparam logic [23:0]    PHASE_INC      = PHASE_INC_L[23:0];
  // frame phase in sixteenths: front-end clock high on steps 0,1 of each quarter
  localparam logic [3:0]     STROBE_RISE    = 4'h1;
  localparam logic [3:0]     STROBE_FALL    = 4'h5;
  // sync, filter and drive delay put each bit about three quarters late;
  // sampling one quarter earlier would still read the previous bit
  localparam logic [1:0]     SAMPLE_SKEW    = 2'h3;

  // ----------------------------------------------------------------
  // reset sequence
  // ----------------------------------------------------------------
  localparam int unsigned    RST_LOW_MIN_NS = 10000;
  localparam int unsigned    RST_LOW_CYC    =
    (RST_LOW_MIN_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam logic [7:0]     RST_LOW_CNT    = RST_LOW_CYC[7:0];
  localparam logic [3:0]     TOGGLE_LAST    = 4'h7;
  localparam logic [7:0]     TIE_FRAMES     = 8'h40;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  localparam logic [7:0]     ACCUMULATION_MODE_REGISTER_ADDR   = 8'h00;
  localparam logic [7:0]     SELECT_ADDR    = 8'h04;
  localparam logic [7:0]     STATUS_ADDR    = 8'h08;
  localparam logic [7:0]     COMMAND_ADDR   = 8'h0C;
  localparam int unsigned    WIRING_CONFIG_SELECT_LSB     = 4;
  localparam int unsigned    WIRING_CONFIG_SELECT_MSB     = 5;
  localparam logic [3:0]     SELECT_RST     = 4'hF;
  localparam int unsigned    STAT_RUN       = 0;
  localparam int unsigned    STAT_FE_RST    = 1;
  localparam int unsigned    STAT_TIED_LSB  = 4;
  localparam int unsigned    STAT_TIED_MSB  = 7;
  localparam int unsigned    CMD_RESTART    = 0;

  // ----------------------------------------------------------------
  // phases, bit slots, modes, states
  // ----------------------------------------------------------------
  localparam int unsigned    NUM_PH         = 4;
  localparam int unsigned    PH_B           = 1;
  localparam int unsigned    PH_N           = 3;
  localparam int unsigned    SLOT_V1        = 0;
  localparam int unsigned    SLOT_V2        = 1;
  localparam int unsigned    SLOT_TOFS      = 2;
  localparam int unsigned    SLOT_I         = 3;

  typedef enum logic [1:0] {
    WIRE_WYE    = 2'h0,
    WIRE_DELTA3 = 2'h1,
    WIRE_DELTA4 = 2'h2,
    WIRE_SPARE  = 2'h3
  } emlm_wiring_type;

  typedef enum logic [2:0] {
    ST_RUN     = 3'h0,
    ST_PIN_LOW = 3'h1,
    ST_ALIGN   = 3'h2,
    ST_TOGGLE  = 3'h3
  } emlm_state_type;

endpackage

// ===== hdl/emlm_slot_if.sv
// bit-slot timing shared from the link timer to the frame splitters
`timescale 1ns/1ns
interface emlm_slot_if;
  logic       sample;
  logic [1:0] slot;
  logic       run;
  modport src (output sample, output slot, output run);
  modport snk (input sample, input slot, input run);
endinterface

// ===== hdl/emlm_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module emlm_pin_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  // pin and filtered level
  input  wire logic pin_i,
  output logic      level_o
);

  logic s1_q, s2_q, s3_q, lvl_q;
  logic s1_d, s2_d, s3_d, lvl_d;

  // s1 feeds only s2; the level moves once s2 and s3 agree
  always_comb begin
    s1_d  = pin_i;
    s2_d  = s1_q;
    s3_d  = s2_q;
    lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      s1_q  <= RESET_VAL;
      s2_q  <= RESET_VAL;
      s3_q  <= RESET_VAL;
      lvl_q <= RESET_VAL;
    end else begin
      s1_q  <= s1_d;
      s2_q  <= s2_d;
      s3_q  <= s3_d;
      lvl_q <= lvl_d;
    end
  end

  assign level_o = lvl_q;

endmodule

// ===== hdl/emlm_frame_split.sv
// splits one phase's four-bit frames into channel bits, zeroing tied inputs
`timescale 1ns/1ns
module emlm_frame_split (
  // clock and reset
  input  wire logic      mclk_i,
  input  wire logic      sys_rst_i,
  // slot timing
  emlm_slot_if.snk       slot_if,
  // phase data
  input  wire logic      data_i,
  input  wire logic      force_zero_i,
  // channel bits: v1, v2, temperature offset, current
  output logic [3:0]     bits_o,
  output logic           valid_o,
  output logic           tied_o
);

  logic [3:0] frame_q, frame_d;
  logic [3:0] bits_q, bits_d;
  logic       valid_q, valid_d;
  logic [7:0] tie_cnt_q, tie_cnt_d;
  logic       tied;
  logic [3:0] whole;

  assign tied = (tie_cnt_q == emlm_pkg::TIE_FRAMES);

  always_comb begin
    frame_d   = frame_q;
    bits_d    = bits_q;
    valid_d   = 1'b0;
    tie_cnt_d = tie_cnt_q;
    whole     = frame_q;
    if (slot_if.sample) begin
      frame_d[slot_if.slot] = data_i;
      whole[slot_if.slot]   = data_i;
      if (slot_if.slot == 2'(emlm_pkg::SLOT_I)) begin
        if (&whole) begin
          if (!tied) begin
            tie_cnt_d = tie_cnt_q + 8'h01;
          end
        end else begin
          tie_cnt_d = 8'h00;
        end
        if (tied || force_zero_i || !slot_if.run) begin
          bits_d = 4'h0;
        end else begin
          bits_d = whole;
        end
        valid_d = slot_if.run;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      frame_q   <= 4'h0;
      bits_q    <= 4'h0;
      valid_q   <= 1'b0;
      tie_cnt_q <= 8'h00;
    end else begin
      frame_q   <= frame_d;
      bits_q    <= bits_d;
      valid_q   <= valid_d;
      tie_cnt_q <= tie_cnt_d;
    end
  end

  assign bits_o  = bits_q;
  assign valid_o = valid_q;
  assign tied_o  = tied;

endmodule

// ===== hdl/emlm_link_manager.sv
// master-side manager for up to four isolated sigma-delta front ends
//
// Operation
// - master drives 4.096 MHz front-end clock
// - reset held 10us then released starts sequence
// - selects toggle 8 times at front-end clock
// - then reset enable and selects go high
// - select low converts second voltage input
// - shared strobe runs at 1.024 MHz
// - shared strobe plus one data line per phase
// - tied-high input yields full-scale samples
// - tied-high samples and derived quantities become zero
// - 3-wire delta: B and neutral tied high
// - 4-wire delta: neutral tied high
// - mode bits 5:4 select wiring configuration
// - strobe is 1/4 rate, 25% duty
// - strobe rises quarter cycle before clock fall
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ns
module emlm_link_manager (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  // register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [31:0]      reg_rdata_o,
  // master reset pin
  input  wire logic        master_reset_n_i,
  // front-end control pins
  output logic             front_end_clock_output_o,
  output logic             strobe_o,
  output logic             slave_reset_enable_n_o,
  output logic             phase_a_channel_select_o,
  output logic             phase_b_channel_select_o,
  output logic             phase_c_channel_select_o,
  output logic             neutral_channel_select_o,
  // per-phase data pins
  input  wire logic        data_a_i,
  input  wire logic        data_b_i,
  input  wire logic        data_c_i,
  input  wire logic        data_n_i,
  // channel bit streams, index is phase a, b, c, neutral
  output logic [3:0]       first_voltage_bit_o,
  output logic [3:0]       second_voltage_bit_o,
  output logic [3:0]       temp_offset_bit_o,
  output logic [3:0]       current_bit_o,
  output logic             bits_valid_o
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  emlm_slot_if slot_if ();

  logic [23:0]              acc_q, acc_d;
  logic [1:0]               slot_prev_q, slot_prev_d;
  logic                     fe_clk_q, fe_clk_d;
  logic                     strobe_q, strobe_d;
  logic [3:0]               step;
  logic                     fe_clk_now;
  logic                     fe_fall;

  emlm_pkg::emlm_state_type state_q, state_d;
  logic [7:0]               low_cnt_q, low_cnt_d;
  logic [3:0]               tog_cnt_q, tog_cnt_d;
  logic                     rst_en_n_q, rst_en_n_d;
  logic [3:0]               sel_q, sel_d;
  logic                     rst_pin;

  logic [1:0]               wiring_config_select_q, wiring_config_select_d;
  logic [3:0]               sel_ctl_q, sel_ctl_d;
  logic [31:0]              rdata_q, rdata_d;
  logic                     restart;

  logic [3:0]               data_pin;
  logic [3:0]               data_lvl;
  logic [3:0]               force_zero;
  logic [3:0]               tied;
  logic [3:0]               ph_valid;
  logic [3:0]               ph_bits [emlm_pkg::NUM_PH];

  assign data_pin = {data_n_i, data_c_i, data_b_i, data_a_i};

  // ----------------------------------------------------------------
  // link timing
  // ----------------------------------------------------------------
  // the 10 MHz clock cannot divide 4.096 MHz evenly, so a phase
  // accumulator tracks the frame; edges jitter by one mclk period
  assign step       = acc_q[23:20];
  assign fe_clk_now = ~acc_q[21];
  assign fe_fall    = fe_clk_q & ~fe_clk_now;

  always_comb begin
    acc_d       = acc_q + emlm_pkg::PHASE_INC;
    slot_prev_d = acc_q[23:22];
    fe_clk_d    = fe_clk_now;
    strobe_d    = (step >= emlm_pkg::STROBE_RISE) && (step < emlm_pkg::STROBE_FALL);
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      acc_q       <= 24'h000000;
      slot_prev_q <= 2'h0;
      fe_clk_q    <= 1'b1;
      strobe_q    <= 1'b0;
    end else begin
      acc_q       <= acc_d;
      slot_prev_q <= slot_prev_d;
      fe_clk_q    <= fe_clk_d;
      strobe_q    <= strobe_d;
    end
  end

  assign slot_if.sample = (acc_q[23:22] != slot_prev_q);
  assign slot_if.slot   = acc_q[23:22] - emlm_pkg::SAMPLE_SKEW;
  assign slot_if.run    = (state_q == emlm_pkg::ST_RUN);

  // ----------------------------------------------------------------
  // front-end reset sequence
  // ----------------------------------------------------------------
  emlm_pin_sync #(
    .RESET_VAL (1'b1)
  ) u_rst_sync (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     (master_reset_n_i),
    .level_o   (rst_pin)
  );

  always_comb begin
    state_d    = state_q;
    low_cnt_d  = low_cnt_q;
    tog_cnt_d  = tog_cnt_q;
    rst_en_n_d = rst_en_n_q;
    sel_d      = sel_q;
    unique case (state_q)
      emlm_pkg::ST_RUN: begin
        rst_en_n_d = 1'b1;
        sel_d      = sel_ctl_q;
        if (!rst_pin) begin
          state_d   = emlm_pkg::ST_PIN_LOW;
          low_cnt_d = 8'h00;
        end else if (restart) begin
          state_d = emlm_pkg::ST_ALIGN;
        end
      end
      emlm_pkg::ST_PIN_LOW: begin
        if (low_cnt_q != emlm_pkg::RST_LOW_CNT) begin
          low_cnt_d = low_cnt_q + 8'h01;
        end
        // long enough low pulse starts sequence
        if (rst_pin) begin
          state_d = (low_cnt_q == emlm_pkg::RST_LOW_CNT) ? emlm_pkg::ST_ALIGN
                                                         : emlm_pkg::ST_RUN;
        end
      end
      emlm_pkg::ST_ALIGN: begin
        rst_en_n_d = 1'b0;
        sel_d      = 4'h0;
        tog_cnt_d  = 4'h0;
        if (fe_fall) begin
          state_d = emlm_pkg::ST_TOGGLE;
        end
      end
      emlm_pkg::ST_TOGGLE: begin
        rst_en_n_d = 1'b0;
        sel_d      = {4{fe_clk_now}};
        if (fe_fall) begin
          tog_cnt_d = tog_cnt_q + 4'h1;
          if (tog_cnt_q == emlm_pkg::TOGGLE_LAST) begin
            state_d    = emlm_pkg::ST_RUN;
            rst_en_n_d = 1'b1;
            sel_d      = 4'hF;
          end
        end
      end
      default: begin
        state_d = emlm_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_q    <= emlm_pkg::ST_RUN;
      low_cnt_q  <= 8'h00;
      tog_cnt_q  <= 4'h0;
      rst_en_n_q <= 1'b1;
      sel_q      <= emlm_pkg::SELECT_RST;
    end else begin
      state_q    <= state_d;
      low_cnt_q  <= low_cnt_d;
      tog_cnt_q  <= tog_cnt_d;
      rst_en_n_q <= rst_en_n_d;
      sel_q      <= sel_d;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  assign restart = reg_wr_i && (reg_addr_i == emlm_pkg::COMMAND_ADDR)
                   && reg_wdata_i[emlm_pkg::CMD_RESTART];

  always_comb begin
    wiring_config_select_d  = wiring_config_select_q;
    sel_ctl_d = sel_ctl_q;
    rdata_d   = 32'h00000000;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        emlm_pkg::ACCUMULATION_MODE_REGISTER_ADDR: wiring_config_select_d =
          reg_wdata_i[emlm_pkg::WIRING_CONFIG_SELECT_MSB:emlm_pkg::WIRING_CONFIG_SELECT_LSB];
        emlm_pkg::SELECT_ADDR:  sel_ctl_d = reg_wdata_i[3:0];
        default: begin
        end
      endcase
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        emlm_pkg::ACCUMULATION_MODE_REGISTER_ADDR:
          rdata_d[emlm_pkg::WIRING_CONFIG_SELECT_MSB:emlm_pkg::WIRING_CONFIG_SELECT_LSB] = wiring_config_select_q;
        emlm_pkg::SELECT_ADDR:
          rdata_d[3:0] = sel_ctl_q;
        emlm_pkg::STATUS_ADDR: begin
          rdata_d[emlm_pkg::STAT_RUN]    = slot_if.run;
          rdata_d[emlm_pkg::STAT_FE_RST] = ~rst_en_n_q;
          rdata_d[emlm_pkg::STAT_TIED_MSB:emlm_pkg::STAT_TIED_LSB] = tied;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      wiring_config_select_q  <= emlm_pkg::WIRE_WYE;
      sel_ctl_q <= emlm_pkg::SELECT_RST;
      rdata_q   <= 32'h00000000;
    end else begin
      wiring_config_select_q  <= wiring_config_select_d;
      sel_ctl_q <= sel_ctl_d;
      rdata_q   <= rdata_d;
    end
  end

  // 3-wire delta drops b and neutral
  always_comb begin
    force_zero = 4'h0;
    unique case (emlm_pkg::emlm_wiring_type'(wiring_config_select_q))
      emlm_pkg::WIRE_DELTA3: begin
        force_zero[emlm_pkg::PH_B] = 1'b1;
        force_zero[emlm_pkg::PH_N] = 1'b1;
      end
      emlm_pkg::WIRE_DELTA4: force_zero[emlm_pkg::PH_N] = 1'b1;
      emlm_pkg::WIRE_WYE,
      emlm_pkg::WIRE_SPARE: force_zero = 4'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // per-phase data paths
  // ----------------------------------------------------------------
  // one data line per phase
  for (genvar p = 0; p < emlm_pkg::NUM_PH; p++) begin : g_phase
    emlm_pin_sync #(
      .RESET_VAL (1'b1)
    ) u_sync (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .pin_i     (data_pin[p]),
      .level_o   (data_lvl[p])
    );
    emlm_frame_split u_split (
      .mclk_i       (mclk_i),
      .sys_rst_i    (sys_rst_i),
      .slot_if      (slot_if.snk),
      .data_i       (data_lvl[p]),
      .force_zero_i (force_zero[p]),
      .bits_o       (ph_bits[p]),
      .valid_o      (ph_valid[p]),
      .tied_o       (tied[p])
    );
    assign first_voltage_bit_o[p]  = ph_bits[p][emlm_pkg::SLOT_V1];
    assign second_voltage_bit_o[p] = ph_bits[p][emlm_pkg::SLOT_V2];
    assign temp_offset_bit_o[p]    = ph_bits[p][emlm_pkg::SLOT_TOFS];
    assign current_bit_o[p]        = ph_bits[p][emlm_pkg::SLOT_I];
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bits_valid_o             = ph_valid[0];
  assign reg_rdata_o              = rdata_q;
  assign front_end_clock_output_o = fe_clk_q;
  assign strobe_o                 = strobe_q;
  assign slave_reset_enable_n_o   = rst_en_n_q;
  assign phase_a_channel_select_o = sel_q[0];
  assign phase_b_channel_select_o = sel_q[1];
  assign phase_c_channel_select_o = sel_q[2];
  assign neutral_channel_select_o = sel_q[3];

endmodule

// ===== dv/emlm_properties.sv
// port-level assertions of the link manager
`timescale 1ns/1ns
module emlm_properties (
  // clock and reset
  input wire logic        mclk_i,
  input wire logic        sys_rst_i,
  // register port
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  // master reset pin
  input wire logic        master_reset_n_i,
  // front-end control
  input wire logic        front_end_clock_output_o,
  input wire logic        strobe_o,
  input wire logic        slave_reset_enable_n_o,
  input wire logic        phase_a_channel_select_o,
  input wire logic        phase_b_channel_select_o,
  input wire logic        phase_c_channel_select_o,
  input wire logic        neutral_channel_select_o,
  // channel bits
  input wire logic [3:0]  first_voltage_bit_o,
  input wire logic [3:0]  current_bit_o,
  input wire logic        bits_valid_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  logic [3:0] sel;
  assign sel = {neutral_channel_select_o, phase_c_channel_select_o,
                phase_b_channel_select_o, phase_a_channel_select_o};
  // bits drop to zero with no valid while a pin pulse holds the block out of run
  logic [3:0] pin_hi_cnt_q;
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || !master_reset_n_i) begin
      pin_hi_cnt_q <= 4'h0;
    end else if (pin_hi_cnt_q != 4'hF) begin
      pin_hi_cnt_q <= pin_hi_cnt_q + 4'h1;
    end
  end

  rd_idle_zero_a: assert property (
    !$past(reg_rd_i) |-> reg_rdata_o == 32'h0) else $error("read data outside slot");
  fe_clock_rate_a: assert property (
    $changed(front_end_clock_output_o) |-> ##[1:2] $changed(front_end_clock_output_o))
    else $error("front-end clock half period wrong");
  strobe_width_a: assert property (
    $rose(strobe_o) |-> strobe_o[*2] ##[1:2] !strobe_o) else $error("strobe width wrong");
  strobe_period_a: assert property (
    $rose(strobe_o) |=> (!$rose(strobe_o))[*8] ##[1:2] $rose(strobe_o))
    else $error("strobe period wrong");
  strobe_phase_a: assert property (
    $rose(strobe_o) |-> ##[0:2] $fell(front_end_clock_output_o))
    else $error("strobe not ahead of clock fall");
  seq_sel_equal_a: assert property (
    !slave_reset_enable_n_o |-> (sel == 4'h0 || sel == 4'hF)) else $error("selects apart");
  seq_end_high_a: assert property (
    $rose(slave_reset_enable_n_o) |-> sel == 4'hF) else $error("selects low at end");
  seq_length_a: assert property (
    $fell(slave_reset_enable_n_o) |-> (!slave_reset_enable_n_o)[*8] ##[9:17]
    slave_reset_enable_n_o) else $error("reset sequence length wrong");
  valid_pulse_a: assert property (
    bits_valid_o |=> !bits_valid_o) else $error("valid longer than one cycle");
  valid_in_run_a: assert property (
    bits_valid_o |-> slave_reset_enable_n_o) else $error("valid during reset sequence");
  bits_hold_a: assert property (
    !bits_valid_o && slave_reset_enable_n_o && $past(slave_reset_enable_n_o) &&
    !$past(reg_wr_i) && pin_hi_cnt_q > 4'h7 |->
    $stable(first_voltage_bit_o) && $stable(current_bit_o))
    else $error("bits changed between frames");

  c_seq: cover property ($rose(slave_reset_enable_n_o));
  c_frame: cover property (bits_valid_o);
  c_read: cover property (reg_rd_i ##1 reg_rdata_o != 32'h0);
endmodule

bind emlm_link_manager emlm_properties i_props (.mclk_i, .sys_rst_i, .reg_wr_i, .reg_rd_i,
  .reg_rdata_o, .master_reset_n_i, .front_end_clock_output_o, .strobe_o,
  .slave_reset_enable_n_o,
  .phase_a_channel_select_o, .phase_b_channel_select_o, .phase_c_channel_select_o,
  .neutral_channel_select_o, .first_voltage_bit_o, .current_bit_o, .bits_valid_o);

// ===== dv/emlm_fe_model.sv
// behavioural model of the four isolated front ends on the bit-stream link
`timescale 1ns/1ns
module emlm_fe_model (
  // link from the master
  input  wire logic        fe_clk_i,
  input  wire logic        strobe_i,
  input  wire logic [3:0]  sel_i,
  // per phase nibble: v1, v2, temperature offset, current
  input  wire logic [15:0] pat_i,
  input  wire logic [3:0]  tie_i,
  // data lines
  output logic [3:0]       data_o
);
  int         slot = 4;
  logic       seen = 1'b0;
  logic [3:0] line = 4'h0;
  always @(negedge fe_clk_i) begin
    #1;
    if (strobe_i && !seen) slot = 0;
    else if (slot < 4) slot++;
    seen = strobe_i;
    for (int p = 0; p < 4; p++) begin
      // past the fourth bit the line is garbage, not the last value
      if (slot < 4) line[p] = pat_i[4*p+slot] ^ (slot == 1 && sel_i[p]);
      else line[p] = ~line[p];
    end
  end
  assign data_o = line | tie_i;
endmodule

// ===== dv/tb_top.sv
// self-checking bench of the link manager
`timescale 1ns/1ns
module tb_top;
  logic        mclk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        pin_n = 1'b1;
  logic [31:0] rdata;
  logic        fe_clk, strobe, rst_en_n, valid;
  wire  [3:0]  sel;
  logic [3:0]  data, v1, v2, tofs, cur;
  logic [3:0]  tie = 4'h0;
  logic [3:0]  selw = 4'hF;
  logic [15:0] pat = 16'h0;
  logic [31:0] seed = 32'h2457;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          cyc = 0;

  emlm_link_manager i_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .master_reset_n_i(pin_n), .front_end_clock_output_o(fe_clk), .strobe_o(strobe),
    .slave_reset_enable_n_o(rst_en_n), .phase_a_channel_select_o(sel[0]),
    .phase_b_channel_select_o(sel[1]), .phase_c_channel_select_o(sel[2]),
    .neutral_channel_select_o(sel[3]), .data_a_i(data[0]), .data_b_i(data[1]),
    .data_c_i(data[2]), .data_n_i(data[3]), .first_voltage_bit_o(v1),
    .second_voltage_bit_o(v2), .temp_offset_bit_o(tofs), .current_bit_o(cur),
    .bits_valid_o(valid));
  // each select wired to its phase's model
  emlm_fe_model i_fe (.fe_clk_i(fe_clk), .strobe_i(strobe), .sel_i(sel), .pat_i(pat),
    .tie_i(tie), .data_o(data));

  initial forever #50 mclk_i = ~mclk_i;

  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch = n_mismatch + 1;
      finish_test();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // zeroed phases follow the wiring field and tied lines; select high reads temperature
  function automatic logic [3:0] exp_nib(input int p, input logic [1:0] m);
    logic [3:0] z;
    z = tie | (m == 2'h1 ? 4'hA : (m == 2'h2 ? 4'h8 : 4'h0));
    return z[p] ? 4'h0 : pat[4*p +: 4] ^ {2'b00, selw[p], 1'b0};
  endfunction

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_i);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic wait_valid(input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      k = 0;
      do begin
        @(posedge mclk_i);
        #1;
        k++;
      end while (valid !== 1'b1 && k < 30);
      if (k >= 30) chk("valid", 32'h0, 32'h1);
    end
  endtask

  task automatic check_bits(input logic [1:0] m);
    wait_valid(6);
    for (int p = 0; p < 4; p++) begin
      chk("bits", {cur[p], tofs[p], v2[p], v1[p]}, exp_nib(p, m));
    end
  endtask

  task automatic seq_watch(input logic start_exp);
    int   k, r;
    logic ps;
    k = 0;
    r = 0;
    do begin
      @(posedge mclk_i);
      #1;
      k++;
    end while (rst_en_n !== 1'b0 && k < 40);
    chk("seq_start", k < 40, start_exp);
    if (k < 40) begin
      ps = sel[0];
      while (rst_en_n === 1'b0 && k < 120) begin
        @(posedge mclk_i);
        #1;
        k++;
        if (rst_en_n === 1'b0 && sel[0] && !ps) r++;
        ps = sel[0];
      end
      chk("toggles", r, 8);
      chk("sel_end", sel, 4'hF);
    end
  endtask

  task automatic finish_test();
    if (n_mismatch == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    logic [31:0] d;
    int          nc, ns;
    logic        pc, ps;
    repeat (3) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    rd_reg(emlm_pkg::ACCUMULATION_MODE_REGISTER_ADDR, d);
    chk("mode_rst", d, 32'h0);
    rd_reg(emlm_pkg::SELECT_ADDR, d);
    chk("sel_rst", d, 32'hF);
    rd_reg(8'h10, d);
    chk("unmapped", d, 32'h0);
    rd_reg(emlm_pkg::STATUS_ADDR, d);
    chk("run", d[1:0], 2'h1);
    // link clock rates over 100 us
    nc = 0;
    ns = 0;
    pc = fe_clk;
    ps = strobe;
    repeat (1000) begin
      @(posedge mclk_i);
      #1;
      nc += int'(fe_clk && !pc);
      ns += int'(strobe && !ps);
      pc = fe_clk;
      ps = strobe;
    end
    chk("fe_clk", nc inside {409, 410}, 1'b1);
    chk("strobe", ns inside {102, 103}, 1'b1);
    // every wiring mode with random selects and patterns
    for (int i = 0; i < 4; i++) begin
      selw = 4'(rnd());
      pat = 16'(rnd()) & 16'hBBBB;
      wr_reg(emlm_pkg::ACCUMULATION_MODE_REGISTER_ADDR, 32'(i) << emlm_pkg::WIRING_CONFIG_SELECT_LSB);
      wr_reg(emlm_pkg::SELECT_ADDR, {28'h0, selw});
      check_bits(i[1:0]);
      chk("sel_pin", sel, selw);
    end
    // phase b tied high
    wr_reg(emlm_pkg::ACCUMULATION_MODE_REGISTER_ADDR, 32'h0);
    tie = 4'h2;
    wait_valid(int'(emlm_pkg::TIE_FRAMES) + 8);
    rd_reg(emlm_pkg::STATUS_ADDR, d);
    chk("tied", d[7:4], 4'h2);
    check_bits(2'h0);
    tie = 4'h0;
    wait_valid(4);
    rd_reg(emlm_pkg::STATUS_ADDR, d);
    chk("untied", d[7:4], 4'h0);
    // front-end reset: long pin pulse, short pin pulse, restart command
    wr_reg(emlm_pkg::SELECT_ADDR, 32'h0);
    @(posedge mclk_i);
    pin_n <= 1'b0;
    repeat (emlm_pkg::RST_LOW_CYC + 10) @(posedge mclk_i);
    pin_n <= 1'b1;
    seq_watch(1'b1);
    @(posedge mclk_i);
    pin_n <= 1'b0;
    repeat (50) @(posedge mclk_i);
    pin_n <= 1'b1;
    seq_watch(1'b0);
    wr_reg(emlm_pkg::COMMAND_ADDR, 32'h1);
    seq_watch(1'b1);
    rd_reg(emlm_pkg::STATUS_ADDR, d);
    chk("run_again", d[1:0], 2'h1);
    finish_test();
  end
endmodule
